// file: blink_timer.v
// backlight blink timer: toggles phase every half period while enabled
// assumes one clock pclk and asynchronous active-low reset
`timescale 1ns/1ps
`include "drive_status_consts.vh"
module blink_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        enable,
    output reg         phase_ff
);
    reg  [24:0] cnt_ff;
    // the count is a 32-bit constant; the half period fits in 25 bits
    wire [31:0] half_full = `BLINK_HALF_CYC;
    wire [24:0] half_cyc  = half_full[24:0];

    // counter held at zero outside trip so each trip starts on white
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff   <= 25'h0000000;
            phase_ff <= 1'b0;
        end else if (!enable) begin
            cnt_ff   <= 25'h0000000;
            phase_ff <= 1'b0;
        end else if (cnt_ff == half_cyc - 25'h0000001) begin
            cnt_ff   <= 25'h0000000;
            phase_ff <= ~phase_ff;
        end else begin
            cnt_ff   <= cnt_ff + 25'h0000001;
        end
    end
endmodule // blink_timer

// file: drive_status_consts.vh
// named constants for the drive status and run-source block
// assumes inclusion by bare name from the design files
`ifndef DRIVE_STATUS_CONSTS_VH
`define DRIVE_STATUS_CONSTS_VH
`define CLK_HZ            40000000
`define BLINK_PERIOD_MS   1000
`define BLINK_HALF_CYC    ((`CLK_HZ / 1000) * `BLINK_PERIOD_MS / 2)
`define OFS_CTRL          12'h000
`define OFS_STAT          12'h004
`define OFS_IRQ_STAT      12'h008
`define OFS_IRQ_MASK      12'h00c
`define OFS_LINE          12'h010
`define CTRL_RST          32'h00000000
`define MASK_RST          4'h0
`define B_RUN_SRC         0
`define B_FREF_SRC        1
`define B_STOP_EN         2
`define B_RESTART         3
`define B_RETRY           4
`define B_MON_B           5
`define B_FUNC            6
`define B_OPTION          7
`define F_FILT_LO         8
`define F_FILT_HI         10
`define B_ALM_RESET       11
`define MODE_MON_A        3'h0
`define MODE_MON_B        3'h1
`define MODE_FUNC         3'h2
`define MODE_TRIP         3'h3
`define MODE_WARN         3'h4
`define MODE_OPTION       3'h5
`define RUN_STOP          2'h0
`define RUN_FWD           2'h1
`define RUN_REV           2'h2
`define FILT_ALL          3'h0
`define FILT_MAX          3'h4
`define EV_TRIP           0
`define EV_WARN           1
`define EV_RESTART        2
`define EV_STOP_KEY       3
`endif

// file: drive_status_display_control.v
// drive status display, backlight and run-source selection with apb registers
// assumes synchronous inputs from keypad, terminal block and drive core
`timescale 1ns/1ps
`include "drive_status_consts.vh"
module drive_status_display_control (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        forward_run_input,
    input  wire        reverse_run_input,
    input  wire        key_run_fwd,
    input  wire        key_run_rev,
    input  wire        key_stop,
    input  wire [15:0] term_freq_ref,
    input  wire [15:0] key_freq_ref,
    input  wire        power_present,
    input  wire        second_motor_input,
    input  wire        trip_active,
    input  wire        warn_mismatch,
    input  wire [1:0]  drive_direction,
    output reg         backlight_white,
    output reg         backlight_orange,
    output reg  [2:0]  mode_field,
    output reg         motor_field,
    output reg  [1:0]  run_field,
    output reg  [2:0]  filter_field,
    output reg         run_cmd,
    output reg         run_reverse,
    output reg  [15:0] freq_ref,
    output reg         irq
);
    ////////////////////////////////////////////////////////////////////////
    // register file
    reg  [31:0] ctrl_ff;
    reg  [3:0]  irq_stat_ff;
    reg  [3:0]  irq_mask_ff;
    reg         trip_d_ff;
    reg         warn_d_ff;
    reg         power_d_ff;
    reg         run_latch_ff;
    reg         stop_hold_ff;
    reg         run_cmd_ff;
    wire        blink_phase;
    wire        wr_en = psel && penable && pwrite;
    wire        rd_en = psel && !penable && !pwrite;
    wire        addr_ok = (paddr == `OFS_CTRL) || (paddr == `OFS_STAT) ||
                          (paddr == `OFS_IRQ_STAT) || (paddr == `OFS_IRQ_MASK) ||
                          (paddr == `OFS_LINE);
    wire [2:0]  filt_raw = ctrl_ff[`F_FILT_HI:`F_FILT_LO];
    // alarm reset acts in the access cycle only; the bit is never stored
    wire        alarm_reset = wr_en && (paddr == `OFS_CTRL) && pwdata[`B_ALM_RESET];

    ////////////////////////////////////////////////////////////////////////
    // run source and command logic
    reg         nxt_run;
    reg         nxt_rev;
    reg         term_req;
    reg         key_req;
    reg         req_any;
    reg         req_rev;
    reg         restart_ev;
    reg         stop_ev;
    reg         hold_ev;
    always @* begin
        term_req   = forward_run_input || reverse_run_input;
        key_req    = key_run_fwd || key_run_rev;
        req_any    = ctrl_ff[`B_RUN_SRC] ? term_req : key_req;
        req_rev    = ctrl_ff[`B_RUN_SRC] ? (reverse_run_input && !forward_run_input)
                                         : (key_run_rev && !key_run_fwd);
        stop_ev    = key_stop && ctrl_ff[`B_STOP_EN];
        restart_ev = 1'b0;
        hold_ev    = 1'b0;
        nxt_run    = run_latch_ff;
        nxt_rev    = run_reverse;
        if (!power_present) begin
            nxt_run = 1'b0;
        end else if (trip_active) begin
            nxt_run = 1'b0;
        end else if (stop_ev) begin
            nxt_run = 1'b0;
        end else if (!power_d_ff && run_latch_ff) begin
            // power back: resume only if restart selected
            restart_ev = ctrl_ff[`B_RESTART] && req_any;
            // without restart the request must be released before a new run
            hold_ev    = !restart_ev;
            nxt_run    = restart_ev;
        end else if (trip_d_ff && req_any) begin
            // trip just cleared by retry or alarm reset with run held
            restart_ev = ctrl_ff[`B_RETRY] || alarm_reset;
            // no retry and no alarm reset: wait for the run request to drop
            hold_ev    = !restart_ev;
            nxt_run    = restart_ev;
        end else if (stop_hold_ff) begin
            nxt_run = 1'b0;
        end else begin
            nxt_run = req_any;
            nxt_rev = req_rev;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_latch_ff <= 1'b0;
            run_cmd_ff   <= 1'b0;
            stop_hold_ff <= 1'b0;
            trip_d_ff    <= 1'b0;
            warn_d_ff    <= 1'b0;
            power_d_ff   <= 1'b0;
        end else begin
            // latch keeps the wish to run across a power dip, cleared by stop, trip or idle
            run_latch_ff <= power_present ? nxt_run : run_latch_ff;
            run_cmd_ff   <= nxt_run;
            // stop key, or a refused restart, holds off until the request is
            // released; a granted restart lifts the hold
            stop_hold_ff <= stop_ev || hold_ev || (stop_hold_ff && req_any && !restart_ev);
            trip_d_ff    <= trip_active;
            warn_d_ff    <= warn_mismatch;
            power_d_ff   <= power_present;
        end
    end

    // command outputs to the drive core
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cmd      <= 1'b0;
            run_reverse  <= 1'b0;
            freq_ref     <= 16'h0000;
        end else begin
            run_cmd      <= nxt_run && power_present;
            run_reverse  <= nxt_rev;
            freq_ref     <= ctrl_ff[`B_FREF_SRC] ? term_freq_ref : key_freq_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // backlight
    blink_timer u_blink (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (trip_active),
        .phase_ff (blink_phase)
    );

    ////////////////////////////////////////////////////////////////////////
    // status line fields
    reg [2:0] nxt_mode;
    reg [1:0] nxt_run_field;
    // mode priority: trip, warning, then the configuration bits of the control word
    always @* begin
        if (trip_active) begin
            nxt_mode = `MODE_TRIP;
        end else if (warn_mismatch) begin
            nxt_mode = `MODE_WARN;
        end else if (ctrl_ff[`B_OPTION]) begin
            nxt_mode = `MODE_OPTION;
        end else if (ctrl_ff[`B_FUNC]) begin
            nxt_mode = `MODE_FUNC;
        end else if (ctrl_ff[`B_MON_B]) begin
            nxt_mode = `MODE_MON_B;
        end else begin
            nxt_mode = `MODE_MON_A;
        end
    end

    // direction code 3 is not a running state and shows as stopped
    always @* begin
        case (drive_direction)
            `RUN_FWD: nxt_run_field = `RUN_FWD;
            `RUN_REV: nxt_run_field = `RUN_REV;
            default:  nxt_run_field = `RUN_STOP;
        endcase
    end

    // trip overrides the warning colour; each trip blink starts on white
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backlight_white  <= 1'b1;
            backlight_orange <= 1'b0;
        end else if (trip_active) begin
            backlight_white  <= ~blink_phase;
            backlight_orange <= blink_phase;
        end else begin
            backlight_white  <= ~warn_mismatch;
            backlight_orange <= warn_mismatch;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_field       <= `MODE_MON_A;
            motor_field      <= 1'b0;
            run_field        <= `RUN_STOP;
            filter_field     <= `FILT_ALL;
        end else begin
            mode_field   <= nxt_mode;
            motor_field  <= second_motor_input;
            run_field    <= nxt_run_field;
            filter_field <= filt_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave and interrupts
    wire [3:0] ev = {stop_ev, restart_ev, warn_mismatch && !warn_d_ff,
                     trip_active && !trip_d_ff};
    wire        filt_ok  = (pwdata[`F_FILT_HI:`F_FILT_LO] <= `FILT_MAX);
    wire        wr_ctrl  = wr_en && pready && (paddr == `OFS_CTRL);
    wire        wr_stat  = wr_en && pready && (paddr == `OFS_IRQ_STAT);
    wire        wr_mask  = wr_en && pready && (paddr == `OFS_IRQ_MASK);
    wire [2:0]  nxt_filt = filt_ok ? pwdata[`F_FILT_HI:`F_FILT_LO] : filt_raw;
    reg  [31:0] nxt_rdata;

    // one access cycle: pready rises at the edge that closes the setup cycle;
    // pslverr flags an unmapped offset, and such a write changes nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // a filter code above the last view is refused and the old one kept
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= {21'h000000, nxt_filt, pwdata[`B_OPTION:`B_RUN_SRC]};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= `MASK_RST;
        end else if (wr_mask) begin
            irq_mask_ff <= pwdata[3:0];
        end
    end

    // set wins over write-one-to-clear, so an event in the clear cycle is kept
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= `MASK_RST;
            irq         <= 1'b0;
        end else begin
            if (wr_stat) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | ev;
            end else begin
                irq_stat_ff <= irq_stat_ff | ev;
            end
            irq <= |((irq_stat_ff | ev) & irq_mask_ff);
        end
    end

    // read data is loaded at setup so that it stands through the access cycle
    always @* begin
        case (paddr)
            `OFS_CTRL:     nxt_rdata = ctrl_ff;
            `OFS_STAT:     nxt_rdata = {24'h000000, run_reverse, run_cmd_ff,
                                        power_present, warn_mismatch,
                                        trip_active, run_field, blink_phase};
            `OFS_IRQ_STAT: nxt_rdata = {28'h0000000, irq_stat_ff};
            `OFS_IRQ_MASK: nxt_rdata = {28'h0000000, irq_mask_ff};
            `OFS_LINE:     nxt_rdata = {23'h000000, mode_field, motor_field,
                                        run_field, filter_field};
            default:       nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= nxt_rdata;
        end
    end
endmodule // drive_status_display_control

// file: drive_status_display_control_properties.sv
// checker: timing relations on the ports of the drive status block
// assumes the bind below, one clock pclk and presetn async active low
`timescale 1ns/1ps
module drive_status_properties (
    input wire logic       pclk, presetn, psel, penable, pready, pslverr,
    input wire logic       trip_active, warn_mismatch, second_motor_input, motor_field,
    input wire logic       backlight_white, backlight_orange,
    input wire logic [1:0] drive_direction, run_field,
    input wire logic [2:0] mode_field
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready ##0 !pslverr)
        else $error("pready longer than one cycle");
    a_warn_orange: assert property (
        $past(presetn && warn_mismatch && !trip_active) |-> backlight_orange && !backlight_white)
        else $error("warning without orange backlight");
    a_normal_white: assert property (
        $past(presetn && !warn_mismatch && !trip_active) |-> backlight_white && !backlight_orange)
        else $error("normal state without white backlight");
    a_trip_one_colour: assert property (
        $past(presetn && trip_active) |-> backlight_white != backlight_orange)
        else $error("trip backlight not exactly one colour");
    a_trip_entry_white: assert property (
        $rose(trip_active) |=> backlight_white && !backlight_orange)
        else $error("trip blink does not start white");
    a_mode_by_alarm: assert property (
        $past(presetn && (trip_active || warn_mismatch))
            |-> mode_field == ($past(trip_active) ? 3'h3 : 3'h4))
        else $error("mode field wrong under trip or warning");
    a_motor_follows: assert property (
        $past(presetn) |-> motor_field == $past(second_motor_input))
        else $error("motor field does not follow input");
    a_run_status: assert property (
        $past(presetn) |-> run_field == ($past(drive_direction) == 2'h3 ? 2'h0
                                          : $past(drive_direction)))
        else $error("run field does not follow direction");
endmodule // drive_status_properties

bind drive_status_display_control drive_status_properties i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .trip_active(trip_active), .warn_mismatch(warn_mismatch),
    .second_motor_input(second_motor_input), .motor_field(motor_field),
    .backlight_white(backlight_white), .backlight_orange(backlight_orange),
    .drive_direction(drive_direction), .run_field(run_field), .mode_field(mode_field));

// file: keypad_terminal_model.sv
// keypad and terminal switch model: levels {fwd, rev, key fwd, key rev, stop}
// assumes the bench sets want; LAG adds switch latency for a slow operator
`timescale 1ns/1ps
module keypad_terminal_model #(parameter int LAG = 0) (
    input  wire logic       pclk,
    input  wire logic [4:0] want,
    output logic            forward_run_input, reverse_run_input,
    output logic            key_run_fwd, key_run_rev, key_stop
);
    logic [4:0] pipe_ff [0:3] = '{default: 5'h00};
    always @(posedge pclk) begin
        pipe_ff[0] <= want;
        for (int i = 1; i < 4; i++) pipe_ff[i] <= pipe_ff[i-1];
    end
    // terminal run is a plain level held by the external switch
    assign {forward_run_input, reverse_run_input, key_run_fwd, key_run_rev, key_stop} =
        pipe_ff[LAG];
endmodule // keypad_terminal_model

// file: test_drive_status_display_control.sv
// bench: apb reads checked from a queue of expected answers
// assumes a 40 MHz pclk and the keypad model as far side
`timescale 1ns/1ps
module test_drive_status_display_control;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hb14f;
    logic        power_present = 0, second_motor_input = 0, trip_active = 0, warn_mismatch = 0;
    logic        fwd_in, rev_in, kf, kr, ks, backlight_white, backlight_orange;
    logic        motor_field, run_cmd, run_reverse, irq;
    logic [4:0]  want = 5'h00;
    logic [15:0] term_freq_ref = 16'h0, key_freq_ref = 16'h0, freq_ref;
    logic [1:0]  drive_direction = 2'h0, run_field;
    logic [2:0]  mode_field, filter_field;
    logic [32:0] exp_q [$];
    logic [31:0] mctl [3] = '{32'h20, 32'h40, 32'h80};
    logic [2:0]  mexp [3] = '{3'h1, 3'h2, 3'h5};
    int          err_total = 0, num_checks = 0;
    initial forever #12.5 pclk = ~pclk;
    keypad_terminal_model #(.LAG(2)) i_keys (.pclk(pclk), .want(want),
        .forward_run_input(fwd_in), .reverse_run_input(rev_in), .key_run_fwd(kf),
        .key_run_rev(kr), .key_stop(ks));
    drive_status_display_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .forward_run_input(fwd_in),
        .reverse_run_input(rev_in), .key_run_fwd(kf), .key_run_rev(kr), .key_stop(ks),
        .term_freq_ref(term_freq_ref), .key_freq_ref(key_freq_ref),
        .power_present(power_present), .second_motor_input(second_motor_input),
        .trip_active(trip_active), .warn_mismatch(warn_mismatch),
        .drive_direction(drive_direction), .backlight_white(backlight_white),
        .backlight_orange(backlight_orange), .mode_field(mode_field),
        .motor_field(motor_field), .run_field(run_field), .filter_field(filter_field),
        .run_cmd(run_cmd), .run_reverse(run_reverse), .freq_ref(freq_ref), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic test_done;
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is sampled high; the trailing edge keeps psel
    // from being assigned twice in one time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        exp_q.push_back(exp);
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) err_total++;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask
    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    initial begin
        #(25 * 20000);
        err_total++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h0);
        rd(12'h00c, 32'h0);
        rd(12'h010, 32'h0);
        apb(1'b1, 12'h020, 32'hffffffff, 33'h100000000);
        apb(1'b0, 12'h020, 32'h0, 33'h100000000);
        for (int f = 0; f < 6; f++) begin
            wr(12'h000, f << 8);
            rd(12'h010, (f > 4) ? 32'h4 : f);
        end
        for (int j = 0; j < 3; j++) begin
            wr(12'h000, mctl[j]);
            rd(12'h010, {mexp[j], 6'h0});
        end
        wr(12'h000, 32'h0);
        wr(12'h00c, 32'h1);
        warn_mismatch <= 1'b1;
        settle();
        chk({backlight_white, backlight_orange, irq}, 3'b010);
        rd(12'h010, 32'h100);
        trip_active <= 1'b1;
        settle();
        chk({backlight_white, backlight_orange, irq}, 3'b101);
        rd(12'h010, 32'h0c0);
        rd(12'h008, 32'h3);
        wr(12'h008, 32'h3);
        settle();
        chk(irq, 1'b0);
        trip_active <= 1'b0;
        warn_mismatch <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            second_motor_input <= i[2];
            drive_direction <= i[1:0];
            settle();
            rd(12'h010, {3'h0, i[2], (i[1:0] == 2'h3) ? 2'h0 : i[1:0], 3'h0});
        end
        drive_direction <= 2'h0;
        power_present <= 1'b1;
        want <= 5'b10000;
        for (int s = 0; s < 4; s++) begin
            rnd = xs(rnd);
            term_freq_ref <= rnd[15:0];
            key_freq_ref <= rnd[31:16];
            wr(12'h000, s);
            settle();
            chk(freq_ref, s[1] ? rnd[15:0] : rnd[31:16]);
            rd(12'h004, s[0] ? 32'h60 : 32'h20);
        end
        wr(12'h000, 32'h9);
        want <= 5'b01000;
        settle();
        rd(12'h004, 32'he0);
        power_present <= 1'b0;
        settle();
        rd(12'h004, 32'h80);
        wr(12'h008, 32'hf);
        power_present <= 1'b1;
        settle();
        rd(12'h004, 32'he0);
        rd(12'h008, 32'h4);
        wr(12'h000, 32'h0);
        want <= 5'b00100;
        settle();
        want <= 5'b00101;
        settle();
        rd(12'h004, 32'h60);
        want <= 5'b00100;
        wr(12'h000, 32'h4);
        wr(12'h008, 32'hf);
        want <= 5'b00101;
        settle();
        rd(12'h004, 32'h20);
        rd(12'h008, 32'h8);
        wr(12'h000, 32'h1);
        want <= 5'b10000;
        settle();
        rd(12'h004, 32'h60);
        chk(run_cmd, 1'b1);
        trip_active <= 1'b1;
        settle();
        rd(12'h004, 32'h28);
        chk(run_cmd, 1'b0);
        trip_active <= 1'b0;
        settle();
        rd(12'h004, 32'h20);
        wr(12'h000, 32'h11);
        wr(12'h008, 32'hf);
        trip_active <= 1'b1;
        settle();
        trip_active <= 1'b0;
        settle();
        rd(12'h004, 32'h60);
        rd(12'h008, 32'h5);
        wr(12'h000, 32'h1);
        trip_active <= 1'b1;
        settle();
        // trip falls at the edge that closes the setup cycle so the design sees it cleared at the access edge
        fork
            wr(12'h000, 32'h801);
            begin
                @(posedge pclk);
                trip_active <= 1'b0;
            end
        join
        settle();
        rd(12'h004, 32'h60);
        rd(12'h000, 32'h1);
        chk(run_cmd, 1'b1);
        test_done();
    end
endmodule // test_drive_status_display_control
